// [common/sensor_setup_map.vh]
// Register offsets, field positions, reset values and timing counts of the
// sensor status and setup block. Assumes a 100 MHz system clock.
//
// Contract
// - Setup register is 8 bits, read/write, all fields reset to zero.
// - Status bit 4 sets below low limit; clears on read or above low+hyst.
// - Status bit 5 sets above high limit; clears on read or below high-hyst.
// - Status bit 6 sets above critical; clears on read or below crit-hyst.
// - Status bit 7 resets to one, drops on new result, rises on value read.
// - In single and once-per-second modes, mode write returns bit 7 to one.
// - Setup bits [1:0] choose one to four faults before alarms assert.
// - Setup bit 2 sets critical alarm pin polarity, zero active low.
// - Setup bit 3 sets limit alarm pin polarity, zero active low.
// - Setup bit 4 picks interrupt (zero) or comparator (one) alarm style.
// - Mode 00 converts continuously, restarting after each completion.
// - Mode 01 performs one conversion of typically 240 ms.
// - Mode 10 converts once per second, each conversion typically 60 ms.
// - Mode 11 shuts down all but register access.
// - Setup bit 7 picks 13-bit (zero) or 16-bit (one) resolution.
// - Low byte bits 2:0 carry flags at 13 bits, extra result bits at 16.
// - Hysteresis is 4-bit whole degrees, subtracted from high/crit, added to low.
// - Critical event drives critical alarm pin; high/low events drive limit pin.
`ifndef SENSOR_SETUP_MAP_VH
`define SENSOR_SETUP_MAP_VH
`define REG_TEMP_MSB 8'h00
`define REG_TEMP_LSB 8'h01
`define REG_STATUS 8'h02
`define REG_SETUP 8'h03
`define REG_HIGH_MSB 8'h04
`define REG_HIGH_LSB 8'h05
`define REG_LOW_MSB 8'h06
`define REG_LOW_LSB 8'h07
`define REG_CRIT_MSB 8'h08
`define REG_CRIT_LSB 8'h09
`define REG_HYST 8'h0A
`define REG_IDENT 8'h0B
`define SETUP_RESET 8'h00
`define STATUS_RESET 8'h80
`define HIGH_RESET 16'h2000
`define LOW_RESET 16'h0500
`define CRIT_RESET 16'h4980
`define HYST_RESET 8'h05
`define FAULT_LSB 0
`define CRIT_POL_BIT 2
`define LIMIT_POL_BIT 3
`define STYLE_BIT 4
`define MODE_LSB 5
`define RES_BIT 7
`define UNDER_BIT 4
`define OVER_BIT 5
`define CRIT_BIT 6
`define NOT_FRESH_BIT 7
`define MODE_CONT 2'b00
`define MODE_SINGLE 2'b01
`define MODE_ONE_SPS 2'b10
`define MODE_SHUTDOWN 2'b11
`define CLK_MHZ 100
`define SINGLE_CONV_MS 240
`define ONE_SPS_CONV_MS 60
`define CONT_CONV_MS 240
`define PERIOD_MS 1000
`define MS_TO_CYC(ms) ((ms) * 1000 * `CLK_MHZ)
`endif

// [rtl/temp_sensor_status_config.v]
// Status and setup registers of the temperature sensor, with the conversion
// scheduler, limit comparison, fault counting and the two alarm pins.
// Assumes the serial interface logic presents byte reads and writes as
// one-cycle strobes with an address, and that the converter core delivers
// a 16-bit twos-complement result when asked to start.
`timescale 1ns/1ps
`include "sensor_setup_map.vh"

module temp_sensor_status_config #(
  parameter [31:0] SINGLE_CYC = `MS_TO_CYC(`SINGLE_CONV_MS),
  parameter [31:0] CONT_CYC = `MS_TO_CYC(`CONT_CONV_MS),
  parameter [31:0] SPS_CONV_CYC = `MS_TO_CYC(`ONE_SPS_CONV_MS),
  parameter [31:0] SPS_PERIOD_CYC = `MS_TO_CYC(`PERIOD_MS),
  parameter [7:0] IDENT_VALUE = 8'h5A // Arbitrary value.
)(
  input wire clk_sys,
  input wire nrst,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  input wire [15:0] adc_result,
  output wire conv_active,
  output wire critical_alarm_pin,
  output wire critical_alarm_oe_n,
  output wire limit_alarm_pin,
  output wire limit_alarm_oe_n
);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  reg [7:0] setup_r;
  reg [15:0] high_r;
  reg [15:0] low_r;
  reg [15:0] crit_r;
  reg [7:0] hyst_r;
  reg [15:0] temp_r;
  reg under_r;
  reg over_r;
  reg crit_flag_r;
  reg not_fresh_r;
  reg [2:0] under_cnt_r;
  reg [2:0] over_cnt_r;
  reg [2:0] crit_cnt_r;
  reg limit_act_r;
  reg crit_act_r;
  reg [31:0] tmr_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg single_req_r;
  reg cmp_lo_r;
  reg cmp_hi_r;

  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_CONV = 2'd1;
  localparam [1:0] ST_WAIT = 2'd2;

  wire [1:0] mode = setup_r[`MODE_LSB+1:`MODE_LSB];
  wire [1:0] wr_mode = reg_wdata[`MODE_LSB+1:`MODE_LSB];
  wire [2:0] fault_need = {1'b0, setup_r[`FAULT_LSB+1:`FAULT_LSB]} + 3'd1;
  wire wr_setup = reg_wr && (reg_addr == `REG_SETUP);
  wire rd_status = reg_rd && (reg_addr == `REG_STATUS);
  wire rd_temp = reg_rd && ((reg_addr == `REG_TEMP_MSB) || (reg_addr == `REG_TEMP_LSB));

  // Hysteresis is whole degrees; one degree is 128 counts of the 16-bit code.
  wire signed [17:0] hyst_s = {7'd0, hyst_r[3:0], 7'd0};

  function signed [17:0] sx;
    input [15:0] v;
    begin
      sx = {{2{v[15]}}, v};
    end
  endfunction

  function [2:0] sat_inc;
    input [2:0] c;
    begin
      sat_inc = (c == 3'd4) ? c : c + 3'd1;
    end
  endfunction

  function sps_or_single;
    input [1:0] m;
    begin
      sps_or_single = (m == `MODE_SINGLE) || (m == `MODE_ONE_SPS);
    end
  endfunction

  // ----------------------------------------------------------------------
  // Conversion scheduler
  // ----------------------------------------------------------------------
  wire [31:0] conv_len = (mode == `MODE_SINGLE) ? SINGLE_CYC :
                         (mode == `MODE_ONE_SPS) ? SPS_CONV_CYC : CONT_CYC;
  wire conv_done = (state_r == ST_CONV) && (tmr_r >= conv_len - 32'd1);
  assign conv_active = (state_r == ST_CONV);

  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (mode == `MODE_CONT || mode == `MODE_ONE_SPS || single_req_r)
          state_nxt = ST_CONV;
      ST_CONV:
        if (mode == `MODE_SHUTDOWN)
          state_nxt = ST_IDLE;
        else if (conv_done)
          state_nxt = (mode == `MODE_ONE_SPS) ? ST_WAIT : ST_IDLE;
      // The idle cycle between two conversions belongs to the period.
      ST_WAIT:
        if (mode != `MODE_ONE_SPS || tmr_r >= SPS_PERIOD_CYC - 32'd2)
          state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= ST_IDLE;
      tmr_r <= 32'd0;
      single_req_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_r == ST_IDLE || state_nxt == ST_IDLE)
        tmr_r <= 32'd0;
      else
        tmr_r <= tmr_r + 32'd1;
      // A single conversion is armed by each write that selects that mode.
      if (wr_setup && wr_mode == `MODE_SINGLE)
        single_req_r <= 1'b1;
      else if (state_r == ST_IDLE && single_req_r)
        single_req_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Limit comparison and flags
  // ----------------------------------------------------------------------
  wire signed [17:0] res_s = sx(adc_result);
  wire is_under = res_s < sx(low_r);
  wire is_over = res_s > sx(high_r);
  wire is_crit = res_s > sx(crit_r);
  wire clr_under = res_s > sx(low_r) + hyst_s;
  wire clr_over = res_s < sx(high_r) - hyst_s;
  wire clr_crit = res_s < sx(crit_r) - hyst_s;
  wire [2:0] under_inc = sat_inc(under_cnt_r);
  wire [2:0] over_inc = sat_inc(over_cnt_r);
  wire [2:0] crit_inc = sat_inc(crit_cnt_r);
  wire lim_trip = (is_under && under_inc >= fault_need) || (is_over && over_inc >= fault_need);
  wire crit_trip = is_crit && crit_inc >= fault_need;
  wire mode_sps_or_single = sps_or_single(mode) || sps_or_single(wr_mode);

  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      temp_r <= 16'h0000;
      under_r <= 1'b0;
      over_r <= 1'b0;
      crit_flag_r <= 1'b0;
      not_fresh_r <= 1'b1;
      under_cnt_r <= 3'd0;
      over_cnt_r <= 3'd0;
      crit_cnt_r <= 3'd0;
      limit_act_r <= 1'b0;
      crit_act_r <= 1'b0;
    end
    else
    begin
      // Flag sets beat a status read in the same cycle.
      if (conv_done)
      begin
        temp_r <= adc_result;
        under_cnt_r <= is_under ? under_inc : 3'd0;
        over_cnt_r <= is_over ? over_inc : 3'd0;
        crit_cnt_r <= is_crit ? crit_inc : 3'd0;
      end
      if (conv_done && is_under)
        under_r <= 1'b1;
      else if (rd_status || (conv_done && clr_under))
        under_r <= 1'b0;
      if (conv_done && is_over)
        over_r <= 1'b1;
      else if (rd_status || (conv_done && clr_over))
        over_r <= 1'b0;
      if (conv_done && is_crit)
        crit_flag_r <= 1'b1;
      else if (rd_status || (conv_done && clr_crit))
        crit_flag_r <= 1'b0;
      if (conv_done)
        not_fresh_r <= 1'b0;
      else if (rd_temp || (wr_setup && mode_sps_or_single))
        not_fresh_r <= 1'b1;
      // Comparator style follows the temperature with hysteresis; interrupt
      // style latches until any register read, as a serviced interrupt.
      if (conv_done && lim_trip)
        limit_act_r <= 1'b1;
      else if (setup_r[`STYLE_BIT] ? (conv_done && !is_under && !is_over &&
               (clr_under || !cmp_lo_r) && (clr_over || !cmp_hi_r)) : reg_rd)
        limit_act_r <= 1'b0;
      if (conv_done && crit_trip)
        crit_act_r <= 1'b1;
      else if (setup_r[`STYLE_BIT] ? (conv_done && clr_crit) : reg_rd)
        crit_act_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Comparator tracking
  // ----------------------------------------------------------------------
  // Each side remembers its own trip, so a status read that clears the
  // flags cannot release a comparator-style alarm inside the hysteresis.
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      cmp_lo_r <= 1'b0;
      cmp_hi_r <= 1'b0;
    end
    else if (conv_done)
    begin
      if (is_under && under_inc >= fault_need)
        cmp_lo_r <= 1'b1;
      else if (clr_under)
        cmp_lo_r <= 1'b0;
      if (is_over && over_inc >= fault_need)
        cmp_hi_r <= 1'b1;
      else if (clr_over)
        cmp_hi_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      setup_r <= `SETUP_RESET;
      high_r <= `HIGH_RESET;
      low_r <= `LOW_RESET;
      crit_r <= `CRIT_RESET;
      hyst_r <= `HYST_RESET;
    end
    else if (reg_wr)
    begin
      // Status, value and identity writes fall through and are ignored.
      case (reg_addr)
        `REG_SETUP: setup_r <= reg_wdata;
        `REG_HIGH_MSB: high_r[15:8] <= reg_wdata;
        `REG_HIGH_LSB: high_r[7:0] <= reg_wdata;
        `REG_LOW_MSB: low_r[15:8] <= reg_wdata;
        `REG_LOW_LSB: low_r[7:0] <= reg_wdata;
        `REG_CRIT_MSB: crit_r[15:8] <= reg_wdata;
        `REG_CRIT_LSB: crit_r[7:0] <= reg_wdata;
        `REG_HYST: hyst_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------------
  wire [7:0] temp_lo = setup_r[`RES_BIT] ? temp_r[7:0] :
                       {temp_r[7:3], crit_flag_r, over_r, under_r};
  wire [7:0] status_val = {not_fresh_r, crit_flag_r, over_r, under_r, 4'h0};

  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `REG_TEMP_MSB: reg_rdata <= temp_r[15:8];
        `REG_TEMP_LSB: reg_rdata <= temp_lo;
        `REG_STATUS: reg_rdata <= status_val;
        `REG_SETUP: reg_rdata <= setup_r;
        `REG_HIGH_MSB: reg_rdata <= high_r[15:8];
        `REG_HIGH_LSB: reg_rdata <= high_r[7:0];
        `REG_LOW_MSB: reg_rdata <= low_r[15:8];
        `REG_LOW_LSB: reg_rdata <= low_r[7:0];
        `REG_CRIT_MSB: reg_rdata <= crit_r[15:8];
        `REG_CRIT_LSB: reg_rdata <= crit_r[7:0];
        `REG_HYST: reg_rdata <= hyst_r;
        `REG_IDENT: reg_rdata <= IDENT_VALUE;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Alarm pins
  // ----------------------------------------------------------------------
  // Open-drain style is left to the pad; both levels are driven here.
  assign critical_alarm_pin = crit_act_r ~^ setup_r[`CRIT_POL_BIT];
  assign limit_alarm_pin = limit_act_r ~^ setup_r[`LIMIT_POL_BIT];
  assign critical_alarm_oe_n = 1'b0;
  assign limit_alarm_oe_n = 1'b0;

endmodule

// [bench/temp_sensor_status_config_assertions.sv]
// Checker bound to the ports of the sensor status and setup block.
// Assumes register writes land on the edge that takes the strobe.
`timescale 1ns/1ps
module sensor_checker #(
  parameter [31:0] SINGLE_CYC = 32'h0000_0014
)(
  input wire clk_sys,
  input wire nrst,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire conv_active,
  input wire critical_alarm_pin,
  input wire critical_alarm_oe_n,
  input wire limit_alarm_pin,
  input wire limit_alarm_oe_n
);
  // A shadow of setup lets the properties see mode and polarity.
  reg [7:0] set_r;
  reg [31:0] run_r;
  wire set_wr = reg_wr && reg_addr == 8'h03;
  wire keep = {reg_wdata[6:4], reg_wdata[1:0]} == {set_r[6:4], set_r[1:0]};
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      set_r <= 8'h00;
      run_r <= 32'h0000_0000;
    end
    else
    begin
      if (set_wr)
        set_r <= reg_wdata;
      run_r <= conv_active ? run_r + 32'h0000_0001 : 32'h0000_0000;
    end
  end
  // --------------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  AST_PINS_DRIVEN: assert property (!critical_alarm_oe_n && !limit_alarm_oe_n)
    else $error("alarm pin released");
  AST_SETUP_RW: assert property (set_wr ##1 reg_rd && reg_addr == 8'h03
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("setup readback wrong");
  AST_STATUS_LOW: assert property (reg_rd && reg_addr == 8'h02
    |=> reg_rdata[3:0] == 4'h0) else $error("status low bits set");
  AST_SHUTDOWN: assert property (set_r[6:5] == 2'b11 [*3] |-> !conv_active)
    else $error("conversion in shutdown");
  AST_CONV_LEN: assert property (run_r <= SINGLE_CYC) else $error("conversion too long");
  AST_CONT_RESTART: assert property ($fell(conv_active) && set_r[6:5] == 2'b00
    |=> conv_active) else $error("no restart");
  AST_CRIT_POL: assert property (set_wr && keep && reg_wdata[2] != set_r[2] &&
    conv_active && !$past(reg_rd) ##1 (conv_active && !reg_rd) [*2]
    |-> critical_alarm_pin != $past(critical_alarm_pin, 2)) else $error("crit polarity");
  AST_LIMIT_POL: assert property (set_wr && keep && reg_wdata[3] != set_r[3] &&
    conv_active && !$past(reg_rd) ##1 (conv_active && !reg_rd) [*2]
    |-> limit_alarm_pin != $past(limit_alarm_pin, 2)) else $error("limit polarity");
  AST_INT_READ_CLR: assert property (reg_rd && !set_r[4] && conv_active ##1 conv_active
    |-> critical_alarm_pin == !set_r[2] && limit_alarm_pin == !set_r[3])
    else $error("read kept alarm");
  COV_SHUTDOWN: cover property (set_r[6:5] == 2'b11 && !conv_active);
  COV_CRIT: cover property ($fell(critical_alarm_pin));
  COV_POL: cover property (set_wr && reg_wdata[3] != set_r[3]);
endmodule

// [bench/adc_model.sv]
// Converter model facing the block; it delivers the sample the bench picks.
// Assumes the same clock and reset as the block.
`timescale 1ns/1ps
module adc_model (
  input wire clk_sys,
  input wire nrst,
  input wire conv_active,
  input wire [15:0] sample,
  output reg [15:0] adc_result
);
  // Outside a conversion the bus churns, so a stale value is never reused.
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      adc_result <= 16'h0000;
    else
      adc_result <= conv_active ? sample : ~adc_result;
  end
endmodule

// [bench/test_temp_sensor_status_config.sv]
// Self-checking bench of the sensor status and setup block.
// Assumes shortened conversion counts of 20, 20, 10 and 40 cycles.
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons = comparisons + 1; if ((g) !== (e)) begin \
  miscompares = miscompares + 1; $display("FAIL %s expected %h seen %h", n, e, g); end end
module test_temp_sensor_status_config;
  reg clk_sys = 1'b0;
  reg nrst = 1'b0;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [7:0] reg_wdata = 8'h00;
  reg [15:0] sample = 16'h0A00;
  wire [7:0] reg_rdata;
  wire [15:0] adc_result;
  wire conv_active;
  wire crit;
  wire lim;
  integer miscompares = 0;
  integer comparisons = 0;
  integer seed = 32'h7a47_6e62;
  integer i;
  integer k;
  reg [31:0] r;
  reg [7:0] d;
  always #5 clk_sys = ~clk_sys;
  temp_sensor_status_config #(.SINGLE_CYC(32'h0000_0014), .CONT_CYC(32'h0000_0014),
    .SPS_CONV_CYC(32'h0000_000A), .SPS_PERIOD_CYC(32'h0000_0028)) u_temp_sensor_status_config (
    .clk_sys(clk_sys), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .adc_result(adc_result),
    .conv_active(conv_active), .critical_alarm_pin(crit), .critical_alarm_oe_n(),
    .limit_alarm_pin(lim), .limit_alarm_oe_n());
  adc_model u_adc_model (.clk_sys(clk_sys), .nrst(nrst), .conv_active(conv_active),
    .sample(sample), .adc_result(adc_result));
  function [7:0] exp_lsb(input [15:0] v, input r16, input [2:0] f);
    exp_lsb = r16 ? v[7:0] : {v[7:3], f};
  endfunction
  task wr(input [7:0] a, input [7:0] v);
  begin
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  end
  endtask
  task rd(input [7:0] a);
  begin
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    d = reg_rdata;
    @(negedge clk_sys);
  end
  endtask
  task rc(input [7:0] a, input [7:0] e);
  begin
    rd(a);
    `CHK("register", e, d)
  end
  endtask
  task wait_lvl(input v);
    for (i = 0; i < 99 && conv_active !== v; i = i + 1) @(negedge clk_sys);
  endtask
  task conv_end;
  begin
    wait_lvl(1'b1);
    wait_lvl(1'b0);
    repeat (2) @(negedge clk_sys);
  end
  endtask
  task end_of_test;
  begin
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial
  begin
    repeat (16) @(negedge clk_sys);
    nrst = 1'b1;
    rc(8'h03, 8'h00);
    rc(8'h02, 8'h80);
    wr(8'h02, 8'h55);
    rc(8'h02, 8'h80);
    rc(8'h30, 8'h00);
    for (k = 0; k < 4; k = k + 1)
    begin
      r = $random(seed);
      wr(8'h03, r[7:0] & 8'h9F);
      rc(8'h03, r[7:0] & 8'h9F);
    end
    wr(8'h03, 8'h00);
    sample = 16'h0800 + {4'h0, r[19:8]};
    conv_end;
    rc(8'h02, 8'h00);
    rc(8'h00, sample[15:8]);
    rc(8'h01, exp_lsb(sample, 1'b0, 3'b000));
    rc(8'h02, 8'h80);
    wr(8'h03, 8'h80);
    conv_end;
    rc(8'h01, exp_lsb(sample, 1'b1, 3'b000));
    wr(8'h03, 8'h00);
    sample = 16'h3000;
    conv_end;
    `CHK("limit pin", 1'b0, lim)
    `CHK("crit pin", 1'b1, crit)
    rc(8'h02, 8'h20);
    rc(8'h02, 8'h00);
    `CHK("limit pin", 1'b1, lim)
    sample = 16'h5000;
    conv_end;
    `CHK("crit pin", 1'b0, crit)
    rc(8'h01, exp_lsb(sample, 1'b0, 3'b110));
    rc(8'h02, 8'hE0);
    wr(8'h03, 8'h1C);
    sample = 16'h0100;
    conv_end;
    `CHK("limit pin", 1'b1, lim)
    rc(8'h02, 8'h10);
    `CHK("limit pin", 1'b1, lim)
    sample = 16'h0600;
    conv_end;
    `CHK("limit pin", 1'b1, lim)
    sample = 16'h0800;
    conv_end;
    `CHK("limit pin", 1'b0, lim)
    wait_lvl(1'b1);
    repeat (2) @(negedge clk_sys);
    wr(8'h03, 8'h10);
    repeat (3) @(negedge clk_sys);
    `CHK("limit pin", 1'b1, lim)
    for (k = 0; k < 4; k = k + 1)
    begin
      sample = 16'h0800;
      wr(8'h03, k[7:0]);
      rc(8'h03, k[7:0]);
      conv_end;
      sample = 16'h3000;
      repeat (k)
      begin
        conv_end;
        `CHK("limit pin", 1'b1, lim)
      end
      conv_end;
      `CHK("limit pin", 1'b0, lim)
    end
    wr(8'h03, 8'h20);
    rd(8'h02);
    `CHK("ready bit", 1'b1, d[7])
    conv_end;
    rd(8'h02);
    `CHK("ready bit", 1'b0, d[7])
    repeat (60) @(negedge clk_sys);
    `CHK("converting", 1'b0, conv_active)
    wr(8'h03, 8'h40);
    rd(8'h02);
    `CHK("ready bit", 1'b1, d[7])
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    for (k = 0; k < 99 && conv_active === 1'b1; k = k + 1) @(negedge clk_sys);
    wait_lvl(1'b1);
    `CHK("run length", 10, k)
    `CHK("period", 40, k + i)
    wr(8'h03, 8'h60);
    rc(8'h03, 8'h60);
    repeat (30) @(negedge clk_sys);
    `CHK("converting", 1'b0, conv_active)
    end_of_test;
  end
  initial
  begin
    #100000;
    miscompares = miscompares + 1;
    end_of_test;
  end
endmodule
bind temp_sensor_status_config sensor_checker #(.SINGLE_CYC(SINGLE_CYC)) u_sensor_checker (
  .clk_sys(clk_sys), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .conv_active(conv_active),
  .critical_alarm_pin(critical_alarm_pin), .critical_alarm_oe_n(critical_alarm_oe_n),
  .limit_alarm_pin(limit_alarm_pin), .limit_alarm_oe_n(limit_alarm_oe_n));
